// >>> hw/ioexp_pkg.sv
package ioexp_pkg;

    // Serial address layout: fixed upper bits, strap bits, direction bit.
    localparam logic [3:0] ADDR_FIXED   = 4'h4;
    localparam int         ADDR_RW_BIT  = 0;
    localparam logic       RW_READ      = 1'b1;

    // Command byte: the low bits select one of eight registers.
    localparam int         PTR_W        = 3;
    localparam logic [2:0] CMD_IN0      = 3'h0;
    localparam logic [2:0] CMD_IN1      = 3'h1;
    localparam logic [2:0] CMD_OUT0     = 3'h2;
    localparam logic [2:0] CMD_OUT1     = 3'h3;
    localparam logic [2:0] CMD_POL0     = 3'h4;
    localparam logic [2:0] CMD_POL1     = 3'h5;
    localparam logic [2:0] CMD_CFG0     = 3'h6;
    localparam logic [2:0] CMD_CFG1     = 3'h7;

    // Register kind codes held in command bits 2..1.
    localparam logic [1:0] KIND_IN      = 2'h0;
    localparam logic [1:0] KIND_OUT     = 2'h1;
    localparam logic [1:0] KIND_POL     = 2'h2;
    localparam logic [1:0] KIND_CFG     = 2'h3;

    // Reset values of one byte of each writable kind.
    localparam logic [7:0] OUT_RST      = 8'hFF;
    localparam logic [7:0] POL_RST      = 8'h00;
    localparam logic [7:0] CFG_RST      = 8'hFF;

    // Bit counts of a serial byte.
    localparam logic [3:0] RX_LAST      = 4'h8;
    localparam logic [3:0] TX_LAST      = 4'h7;

    // Number of asynchronous inputs passed through the synchroniser.
    localparam int         SYNC_W       = 21;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } bus_state_e;

    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_CMD  = 3'h2,
        PH_DATA = 3'h4
    } phase_e;

endpackage : ioexp_pkg

// >>> hw/i2c_io_expander.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Input, output, polarity, direction registers, two bytes.
// - After reset all sixteen pins are inputs.
// - Each pin direction follows its configuration bit.
// - Input bits hold samples, output bits hold drives.
// - Polarity bit set reports the pin inverted.
// - Every register is readable over the bus.
// - Reset restores registers and idles bus machine.
// - Interrupt when input pin differs from capture.
// - Interrupt is active low, open drain.
// - Three straps set low address bits.
// - Output pins hold last written output value.
// - Output pins are driven push-pull both ways.
// - Address is 0100, straps, then read bit.
// - Command byte low bits select one register.
// - Pointer persists until a new command byte.
// - Input registers follow pins; writes ignored.
module i2c_io_expander (
    // System
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Serial bus
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    // Address straps
    input  wire logic        addr_strap_bit0_i,
    input  wire logic        addr_strap_bit1_i,
    input  wire logic        addr_strap_bit2_i,
    // Port pins, low byte
    input  wire logic [7:0]  port_low_pins_i,
    output logic      [7:0]  port_low_pins_o,
    output logic      [7:0]  port_low_pins_oe_o,
    // Port pins, high byte
    input  wire logic [7:0]  port_high_pins_i,
    output logic      [7:0]  port_high_pins_o,
    output logic      [7:0]  port_high_pins_oe_o,
    // Change interrupt
    output logic             int_n_o,
    output logic             int_oe_o
);

    // Picks the low or high byte of a sixteen-bit register pair.
    function automatic logic [7:0] pick_byte(
        input logic [15:0] pair,
        input logic        hi
    );
        pick_byte = hi ? pair[15:8] : pair[7:0];
    endfunction : pick_byte

    // Two-stage synchroniser for every pin.
    logic [ioexp_pkg::SYNC_W-1:0] async_in;
    logic [ioexp_pkg::SYNC_W-1:0] sync_meta;
    logic [ioexp_pkg::SYNC_W-1:0] sync_q;

    assign async_in = {scl_i, sda_i, addr_strap_bit2_i, addr_strap_bit1_i,
                       addr_strap_bit0_i, port_high_pins_i, port_low_pins_i};

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Bus lines rest high, so no false edge follows reset.
            sync_meta <= {2'b11, {(ioexp_pkg::SYNC_W-2){1'b0}}};
            sync_q    <= {2'b11, {(ioexp_pkg::SYNC_W-2){1'b0}}};
        end else begin
            sync_meta <= async_in;
            sync_q    <= sync_meta;
        end
    end

    logic        scl_s;
    logic        sda_s;
    logic [2:0]  strap_s;
    logic [15:0] pin_s;

    assign scl_s   = sync_q[20];
    assign sda_s   = sync_q[19];
    assign strap_s = sync_q[18:16];
    assign pin_s   = sync_q[15:0];

    // Bus line history for edge and condition detection.
    logic scl_prev;
    logic sda_prev;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_s;
            sda_prev <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_s & ~scl_prev;
    assign scl_fall  = ~scl_s & scl_prev;
    assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
    assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

    // Register storage, one sixteen-bit pair per kind.
    logic [15:0] out_q;
    logic [15:0] pol_q;
    logic [15:0] cfg_q;
    logic [15:0] in_capt;
    logic [ioexp_pkg::PTR_W-1:0] ptr;

    // Serial engine state.
    ioexp_pkg::bus_state_e state;
    ioexp_pkg::phase_e     phase;
    logic [3:0]            bit_cnt;
    logic [7:0]            shreg;
    logic                  rw_read;
    logic                  mack_ok;

    logic       addr_hit;
    logic       byte_done;
    logic       wr_stb;
    logic       ptr_load;
    logic       rd_load;
    logic [7:0] rd_byte;
    logic [7:0] in_now;

    assign addr_hit  = (shreg[7:1] == {ioexp_pkg::ADDR_FIXED, strap_s});
    assign byte_done = (state == ioexp_pkg::ST_RX) && scl_fall
                       && (bit_cnt == ioexp_pkg::RX_LAST);
    assign wr_stb    = byte_done && (phase == ioexp_pkg::PH_DATA);
    assign ptr_load  = byte_done && (phase == ioexp_pkg::PH_CMD);
    assign rd_load   = scl_fall
                       && (((state == ioexp_pkg::ST_ACK) && rw_read
                            && (phase == ioexp_pkg::PH_ADDR))
                           || ((state == ioexp_pkg::ST_MACK) && mack_ok));

    // Live input value of the pointed byte, with polarity applied; the capture keeps raw pin levels.
    assign in_now = pick_byte(pin_s, ptr[0]) ^ pick_byte(pol_q, ptr[0]);

    always_comb begin
        unique case (ptr[2:1])
            ioexp_pkg::KIND_IN:  rd_byte = in_now;
            ioexp_pkg::KIND_OUT: rd_byte = pick_byte(out_q, ptr[0]);
            ioexp_pkg::KIND_POL: rd_byte = pick_byte(pol_q, ptr[0]);
            ioexp_pkg::KIND_CFG: rd_byte = pick_byte(cfg_q, ptr[0]);
        endcase
    end

    // Bus state machine; start and stop override every state.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state   <= ioexp_pkg::ST_IDLE;
            phase   <= ioexp_pkg::PH_ADDR;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            rw_read <= 1'b0;
            mack_ok <= 1'b0;
        end else if (start_det) begin
            state   <= ioexp_pkg::ST_RX;
            phase   <= ioexp_pkg::PH_ADDR;
            bit_cnt <= 4'h0;
        end else if (stop_det) begin
            state   <= ioexp_pkg::ST_IDLE;
        end else begin
            unique case (state)
                ioexp_pkg::ST_IDLE: begin
                    bit_cnt <= 4'h0;
                end
                ioexp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        if (phase == ioexp_pkg::PH_ADDR) begin
                            if (addr_hit) begin
                                state   <= ioexp_pkg::ST_ACK;
                                rw_read <= (shreg[ioexp_pkg::ADDR_RW_BIT]
                                            == ioexp_pkg::RW_READ);
                            end else begin
                                state   <= ioexp_pkg::ST_IDLE;
                            end
                        end else begin
                            state <= ioexp_pkg::ST_ACK;
                        end
                    end
                end
                ioexp_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (rd_load) begin
                            state <= ioexp_pkg::ST_TX;
                            shreg <= rd_byte;
                        end else begin
                            state <= ioexp_pkg::ST_RX;
                            if (phase == ioexp_pkg::PH_ADDR) begin
                                phase <= ioexp_pkg::PH_CMD;
                            end else begin
                                phase <= ioexp_pkg::PH_DATA;
                            end
                        end
                    end
                end
                ioexp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == ioexp_pkg::TX_LAST) begin
                            state   <= ioexp_pkg::ST_MACK;
                            mack_ok <= 1'b0;
                        end else begin
                            shreg   <= {shreg[6:0], 1'b1};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ioexp_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        mack_ok <= ~sda_s;
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (mack_ok) begin
                            state <= ioexp_pkg::ST_TX;
                            shreg <= rd_byte;
                        end else begin
                            state <= ioexp_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Open-drain data line: pull low for acknowledge and zero bits.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_oe_o <= 1'b0;
        end else begin
            sda_oe_o <= (state == ioexp_pkg::ST_ACK)
                        || ((state == ioexp_pkg::ST_TX) && !shreg[7]);
        end
    end

    assign sda_o = 1'b0;

    // Register pointer survives across transfers.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr <= ioexp_pkg::CMD_IN0;
        end else if (ptr_load) begin
            ptr <= shreg[ioexp_pkg::PTR_W-1:0];
        end
    end

    // Writable registers; writes to the input pair fall through unused.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_q <= {ioexp_pkg::OUT_RST, ioexp_pkg::OUT_RST};
            pol_q <= {ioexp_pkg::POL_RST, ioexp_pkg::POL_RST};
            cfg_q <= {ioexp_pkg::CFG_RST, ioexp_pkg::CFG_RST};
        end else if (wr_stb) begin
            unique case (ptr)
                ioexp_pkg::CMD_OUT0: out_q[7:0]  <= shreg;
                ioexp_pkg::CMD_OUT1: out_q[15:8] <= shreg;
                ioexp_pkg::CMD_POL0: pol_q[7:0]  <= shreg;
                ioexp_pkg::CMD_POL1: pol_q[15:8] <= shreg;
                ioexp_pkg::CMD_CFG0: cfg_q[7:0]  <= shreg;
                ioexp_pkg::CMD_CFG1: cfg_q[15:8] <= shreg;
                default: ;
            endcase
        end
    end

    // Input capture: primed once the synchroniser holds real pin levels,
    // renewed by each input read.
    logic       primed;
    logic [1:0] warm;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            primed  <= 1'b0;
            warm    <= 2'h0;
            in_capt <= 16'h0000;
        end else if (!primed) begin
            warm <= {warm[0], 1'b1};
            if (warm[1]) begin
                primed  <= 1'b1;
                in_capt <= pin_s;
            end
        end else if (rd_load && (ptr == ioexp_pkg::CMD_IN0)) begin
            in_capt[7:0]  <= pin_s[7:0];
        end else if (rd_load && (ptr == ioexp_pkg::CMD_IN1)) begin
            in_capt[15:8] <= pin_s[15:8];
        end
    end

    // Change interrupt over pins configured as inputs.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_oe_o <= 1'b0;
        end else begin
            int_oe_o <= primed && |((pin_s ^ in_capt) & cfg_q);
        end
    end

    assign int_n_o = 1'b0;

    // Pin drivers: enabled where configuration holds zero, push-pull.
    assign port_low_pins_o     = out_q[7:0];
    assign port_high_pins_o    = out_q[15:8];
    assign port_low_pins_oe_o  = ~cfg_q[7:0];
    assign port_high_pins_oe_o = ~cfg_q[15:8];

endmodule : i2c_io_expander

// >>> verif/i2c_io_expander_checker.sv
`timescale 1ns/1ps
module i2c_io_expander_checker (
    // Watched ports
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [7:0] port_low_pins_i,
    input wire logic [7:0] port_high_pins_i,
    input wire logic [7:0] port_low_pins_o,
    input wire logic [7:0] port_high_pins_o,
    input wire logic [7:0] port_low_pins_oe_o,
    input wire logic [7:0] port_high_pins_oe_o,
    input wire logic       int_n_o,
    input wire logic       int_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire [15:0] pins = {port_high_pins_i, port_low_pins_i};
    wire [31:0] drv  = {port_high_pins_oe_o, port_low_pins_oe_o,
                        port_high_pins_o, port_low_pins_o};
    int_od_a: assert property (int_n_o == 1'b0)
        else $error("interrupt value not low");
    sda_od_a: assert property (sda_o == 1'b0)
        else $error("data value not low");
    reset_dir_a: assert property ($rose(rst_n_i) |-> drv == 32'h0000FFFF)
        else $error("pins not inputs after reset");
    bus_idle_a: assert property ($rose(rst_n_i) |-> !sda_oe_o && !int_oe_o)
        else $error("bus or interrupt active after reset");
    drv_hold_a: assert property (!$stable(drv) |-> !scl_i)
        else $error("pin drive changed outside a write");
    ack_low_a: assert property (!$stable(sda_oe_o) |-> !scl_i)
        else $error("data line changed while clock high");
    int_rise_a: assert property ($rose(int_oe_o) |-> pins != $past(pins, 6))
        else $error("interrupt without pin change");
    int_clear_a: assert property ($fell(int_oe_o) |->
        !scl_i || pins != $past(pins, 6))
        else $error("interrupt cleared without cause");
endmodule : i2c_io_expander_checker

bind i2c_io_expander i2c_io_expander_checker u_chk (.clk_sys_i, .rst_n_i,
    .scl_i, .sda_o, .sda_oe_o, .port_low_pins_i, .port_high_pins_i,
    .port_low_pins_o, .port_high_pins_o, .port_low_pins_oe_o,
    .port_high_pins_oe_o, .int_n_o, .int_oe_o);

// >>> verif/ioexp_master.sv
`timescale 1ns/1ps
module ioexp_master (
    // Bus wire and drives
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Quarter bit time; the clock stands high between frames.
    int qt = 12;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic start();
        if (scl_o == 1'b0) begin
            #qt sda_o = 1'b1;
            #qt scl_o = 1'b1;
        end
        #qt sda_o = 1'b0;
        #qt scl_o = 1'b0;
    endtask : start
    task automatic stop();
        #qt sda_o = 1'b0;
        #qt scl_o = 1'b1;
        #qt sda_o = 1'b1;
        #qt;
    endtask : stop
    task automatic bit_x(input logic b, output logic r);
        #qt sda_o = b;
        #qt scl_o = 1'b1;
        r = sda_i;
        #(2 * qt) scl_o = 1'b0;
    endtask : bit_x
    task automatic byte_x(input logic [7:0] d, input logic a,
                          output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(a, ak);
    endtask : byte_x
endmodule : ioexp_master

// >>> verif/i2c_io_expander_bench.sv
`timescale 1ns/1ps
module i2c_io_expander_bench;
    logic       clk_sys_i   = 1'b0;
    logic       rst_n_i     = 1'b0;
    logic [2:0] strap       = 3'h0;
    logic [7:0] ext_lo      = 8'h00;
    logic [7:0] ext_hi      = 8'h00;
    logic [7:0] lo_o, lo_oe, hi_o, hi_oe, rv;
    logic       sda_oe, int_oe, scl, m_sda, ak;
    wire        sda_w       = m_sda & ~sda_oe;
    wire  [7:0] lo_w        = (lo_oe & lo_o) | (~lo_oe & ext_lo);
    wire  [7:0] hi_w        = (hi_oe & hi_o) | (~hi_oe & ext_hi);
    wire        int_w       = ~int_oe;
    int         bad_count   = 0;
    int         checks_done = 0;
    int         cycles      = 0;
    i2c_io_expander DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
        .addr_strap_bit0_i(strap[0]), .addr_strap_bit1_i(strap[1]),
        .addr_strap_bit2_i(strap[2]), .port_low_pins_i(lo_w),
        .port_low_pins_o(lo_o), .port_low_pins_oe_o(lo_oe),
        .port_high_pins_i(hi_w), .port_high_pins_o(hi_o),
        .port_high_pins_oe_o(hi_oe), .int_n_o(), .int_oe_o(int_oe));
    ioexp_master m (.sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
    initial forever #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic adr(input logic rw, input logic [2:0] s, input logic e);
        m.start();
        m.byte_x({ioexp_pkg::ADDR_FIXED, s, rw}, 1'b1, rv, ak);
        chk("addr ack", ak, e);
    endtask : adr
    task automatic wr(input logic [2:0] c, input logic [7:0] d);
        adr(1'b0, strap, 1'b0);
        m.byte_x({5'h00, c}, 1'b1, rv, ak);
        chk("cmd ack", ak, 1'b0);
        m.byte_x(d, 1'b1, rv, ak);
        chk("data ack", ak, 1'b0);
        m.stop();
    endtask : wr
    task automatic rd(input logic sc, input logic [2:0] c,
                      input logic [7:0] e);
        if (sc) begin
            adr(1'b0, strap, 1'b0);
            m.byte_x({5'h00, c}, 1'b1, rv, ak);
        end
        adr(ioexp_pkg::RW_READ, strap, 1'b0);
        m.byte_x(8'hFF, 1'b1, rv, ak);
        chk("read", rv, e);
        m.stop();
    endtask : rd
    task automatic t_reset();
        chk("oe", {hi_oe, lo_oe}, 16'h0000);
        chk("out", {hi_o, lo_o}, 16'hFFFF);
        for (int c = 0; c < 8; c++)
            rd(1'b1, c[2:0], (c < 2 || c[2:1] == 2'h2) ? 8'h00 : 8'hFF);
    endtask : t_reset
    task automatic t_out();
        wr(3'h2, 8'hA5);
        wr(3'h6, 8'h00);
        wr(3'h7, 8'hF0);
        chk("oe", {hi_oe, lo_oe}, 16'h0FFF);
        chk("pins", {hi_w[3:0], lo_w}, 16'h0FA5);
        wr(3'h0, 8'h3C);
        rd(1'b1, 3'h0, 8'hA5);
        rd(1'b1, 3'h2, 8'hA5);
    endtask : t_out
    task automatic t_int();
        ext_hi = 8'h30;
        tick(8);
        chk("int", int_w, 1'b0);
        rd(1'b1, 3'h1, 8'h3F);
        chk("int", int_w, 1'b1);
        ext_hi = 8'h20;
        tick(8);
        chk("int", int_w, 1'b0);
        ext_hi = 8'h30;
        tick(8);
        chk("int", int_w, 1'b1);
    endtask : t_int
    task automatic t_pol();
        wr(3'h5, 8'hFF);
        rd(1'b1, 3'h1, 8'hC0);
        rd(1'b0, 3'h1, 8'hC0);
    endtask : t_pol
    task automatic t_addr();
        for (int s = 0; s < 8; s++) begin
            strap = s[2:0];
            tick(4);
            rd(1'b1, 3'h7, 8'hF0);
        end
        m.qt = 100;
        adr(1'b0, ~strap, 1'b1);
        m.stop();
        rd(1'b1, 3'h6, 8'h00);
        m.qt = 12;
    endtask : t_addr
    task automatic t_rst2();
        tick(1);
        rst_n_i = 1'b0;
        tick(2);
        rst_n_i = 1'b1;
        tick(4);
        chk("oe", {hi_oe, lo_oe}, 16'h0000);
        chk("out", {hi_o, lo_o}, 16'hFFFF);
        chk("int", int_w, 1'b1);
        rd(1'b1, 3'h6, 8'hFF);
    endtask : t_rst2
    initial begin
        tick(20);
        rst_n_i = 1'b1;
        tick(4);
        t_reset();
        t_out();
        t_int();
        t_pol();
        t_addr();
        t_rst2();
        final_report();
    end
endmodule : i2c_io_expander_bench
